// ==== verilog/pdc_consts.vh ====
/*
 * constants for the pressure dsp user configuration bank: offsets, field positions,
 * reset values, filter and self-test codes, fixed link values.
 * assumes inclusion by bare name from the design file.
 */
`ifndef PDC_CONSTS_VH
`define PDC_CONSTS_VH

// register offsets
`define PDC_OFS_OUTPUT_TYPE 8'h42
`define PDC_OFS_FILTER_PIN 8'h43
`define PDC_OFS_SELF_TEST 8'h44

// reset values
`define PDC_RST_OUTPUT_TYPE 8'h00
`define PDC_RST_FILTER_PIN 8'h00
`define PDC_RST_SELF_TEST 8'h00
`define PDC_RST_LOWPASS 8'h00
`define PDC_RST_DATA 16'h0000

// field positions
`define PDC_SLOT0_TYPE_HI 6
`define PDC_SLOT0_TYPE_LO 5
`define PDC_SLOT1_TYPE_HI 3
`define PDC_SLOT1_TYPE_LO 2
`define PDC_REF_RESTART_BIT 7
`define PDC_RATE_BYPASS_BIT 4
`define PDC_INT_MODE_BIT 2
`define PDC_SELF_TEST_HI 7
`define PDC_SELF_TEST_LO 4
`define PDC_LOWPASS_HI 7
`define PDC_LOWPASS_LO 4

// slot data type codes
`define PDC_TYPE_REL 2'b00
`define PDC_TYPE_ABS 2'b01
`define PDC_TYPE_REF 2'b10
`define PDC_TYPE_TEMP 2'b11

// lowpass select codes
`define PDC_LPF_370_2P 4'h0
`define PDC_LPF_400_3P 4'h1
`define PDC_LPF_800_4P 4'h2
`define PDC_LPF_1000_4P 4'h3

// self-test codes that force fixed patterns
`define PDC_ST_FORCE_0 4'h4
`define PDC_ST_FORCE_1 4'h5
`define PDC_ST_FORCE_2 4'h6
`define PDC_ST_FORCE_3 4'h7
`define PDC_PAT_0 16'h0000
`define PDC_PAT_1 16'h0AAA
`define PDC_PAT_2 16'h5555
`define PDC_PAT_3 16'hFFFF

// value sent on the psi5 link in place of absolute pressures
`define PDC_PSI5_ABS_SUBST 16'h01F4

// mask of self-test register bits kept in the integrity check; the self-test field stays out
`define PDC_SELF_TEST_CHECK_MASK 8'h0F

`endif

// ==== verilog/pdc_config_bank.v ====
/*
 * pressure dsp user configuration bank: three user registers, filter and slot
 * selection decode, sensor data slots with self-test patterns, link value
 * substitution, reference filter restart and interrupt pin mode.
 * assumes a serial command decoder on the same clock that issues one-cycle read
 * and write strobes, and a dsp path that supplies samples and an init-done level.
 */
`default_nettype none
`include "pdc_consts.vh"

//////////////////////////////////////////////////////////////////////////////
module pdc_config_bank (
    input wire clk_in,
    input wire reset_in,
    // register access from the command decoder
    input wire [7:0] reg_addr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [7:0] reg_rdata_out,
    output reg reg_rd_valid_out,
    output reg reg_refused_out,
    // operating mode
    input wire dsi3_mode_in,
    input wire psi5_diag_mode_in,
    input wire psi5_mode_in,
    // dsp data path
    input wire dsp_init_done_in,
    input wire sample_tick_in,
    input wire interp_tick_in,
    input wire [15:0] rel_pressure_in,
    input wire [15:0] abs_pressure_in,
    input wire [15:0] ref_pressure_in,
    input wire [15:0] temperature_in,
    output reg dsp_path_reset_out,
    output reg [15:0] slot0_data_out,
    output reg [15:0] slot1_data_out,
    output reg [15:0] slot0_link_out,
    output reg [15:0] slot1_link_out,
    output reg data_ready_out,
    // filter steering
    output reg [1:0] lowpass_code_out,
    output reg [2:0] lowpass_poles_out,
    output reg lowpass_reserved_out,
    output reg ref_filter_restart_out,
    output wire ref_rate_limit_bypass_out,
    output wire [3:0] self_test_select_out,
    output wire [7:0] cfg_check_out,
    // interrupt pin
    input wire int_pin_enable_in,
    input wire int_request_in,
    output wire int_pin_out,
    output wire int_pin_oe_out,
    output wire int_pullup_en_out,
    output wire int_pulldown_en_out
);

    //////////////////////////////////////////////////////////////////////////
    // functions

    // pick slot content from its two-bit type code
    function [15:0] slot_pick;
        input [1:0] kind;
        input [15:0] rel_v;
        input [15:0] abs_v;
        input [15:0] ref_v;
        input [15:0] tmp_v;
        begin
            case (kind)
                `PDC_TYPE_REL: slot_pick = rel_v;
                `PDC_TYPE_ABS: slot_pick = abs_v;
                `PDC_TYPE_REF: slot_pick = ref_v;
                default: slot_pick = tmp_v;
            endcase
        end
    endfunction

    // psi5 substitutes a fixed word for either absolute pressure type
    function [15:0] link_word;
        input [1:0] kind;
        input [15:0] reg_v;
        input psi5;
        begin
            if (psi5 && (kind == `PDC_TYPE_ABS || kind == `PDC_TYPE_REF)) begin
                link_word = `PDC_PSI5_ABS_SUBST;
            end else begin
                link_word = reg_v;
            end
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // registers

    reg [7:0] output_type_q;
    reg [7:0] filter_pin_q;
    reg [7:0] self_test_q;
    reg [7:0] lowpass_q;
    reg path_hold_q;

    wire access_ok;
    wire wr_ok;
    wire [1:0] slot0_type;
    wire [1:0] slot1_type;
    wire [3:0] st_code;
    wire st_force;
    reg [15:0] st_pattern;
    wire [15:0] slot0_next;
    wire [15:0] slot1_next;

    // a lowpass field is driven by a neighbouring register outside this bank;
    // here it is held in a private copy fed at reset only, so decode stays local
    assign access_ok = dsi3_mode_in | psi5_diag_mode_in;
    assign wr_ok = reg_wr_in & access_ok;
    assign slot0_type = output_type_q[`PDC_SLOT0_TYPE_HI:`PDC_SLOT0_TYPE_LO];
    assign slot1_type = output_type_q[`PDC_SLOT1_TYPE_HI:`PDC_SLOT1_TYPE_LO];
    assign st_code = self_test_q[`PDC_SELF_TEST_HI:`PDC_SELF_TEST_LO];
    assign self_test_select_out = st_code;
    assign ref_rate_limit_bypass_out = filter_pin_q[`PDC_RATE_BYPASS_BIT];

    // integrity check word; self-test bits stay out so a test mode does not trip it
    assign cfg_check_out = output_type_q ^ filter_pin_q
                         ^ (self_test_q & `PDC_SELF_TEST_CHECK_MASK);

    // register writes, refused outside the permitted modes
    always @(posedge clk_in) begin
        if (reset_in) begin
            output_type_q <= `PDC_RST_OUTPUT_TYPE;
            filter_pin_q <= `PDC_RST_FILTER_PIN;
            self_test_q <= `PDC_RST_SELF_TEST;
            lowpass_q <= `PDC_RST_LOWPASS;
        end else if (wr_ok) begin
            if (reg_addr_in == `PDC_OFS_OUTPUT_TYPE) begin
                output_type_q <= reg_wdata_in;
            end else if (reg_addr_in == `PDC_OFS_FILTER_PIN) begin
                filter_pin_q <= reg_wdata_in;
            end else if (reg_addr_in == `PDC_OFS_SELF_TEST) begin
                self_test_q <= reg_wdata_in;
            end
        end
    end

    // side effects of writes: path reset on change, restart on a rising bit
    always @(posedge clk_in) begin
        if (reset_in) begin
            dsp_path_reset_out <= 1'b0;
            ref_filter_restart_out <= 1'b0;
        end else begin
            dsp_path_reset_out <= wr_ok && reg_addr_in == `PDC_OFS_OUTPUT_TYPE
                                  && reg_wdata_in != output_type_q;
            ref_filter_restart_out <= wr_ok && reg_addr_in == `PDC_OFS_FILTER_PIN
                                      && reg_wdata_in[`PDC_REF_RESTART_BIT]
                                      && !filter_pin_q[`PDC_REF_RESTART_BIT];
        end
    end

    // reads answer one cycle later; refused or unmapped reads return zero
    always @(posedge clk_in) begin
        if (reset_in) begin
            reg_rdata_out <= 8'h00;
            reg_rd_valid_out <= 1'b0;
            reg_refused_out <= 1'b0;
        end else begin
            reg_rd_valid_out <= reg_rd_in & access_ok;
            reg_refused_out <= (reg_rd_in | reg_wr_in) & ~access_ok;
            if (reg_rd_in && access_ok && reg_addr_in == `PDC_OFS_OUTPUT_TYPE) begin
                reg_rdata_out <= output_type_q;
            end else if (reg_rd_in && access_ok && reg_addr_in == `PDC_OFS_FILTER_PIN) begin
                reg_rdata_out <= filter_pin_q;
            end else if (reg_rd_in && access_ok && reg_addr_in == `PDC_OFS_SELF_TEST) begin
                reg_rdata_out <= self_test_q;
            end else begin
                reg_rdata_out <= 8'h00;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // lowpass decode

    // reserved codes keep the default filter so the dsp never runs undefined
    always @* begin
        lowpass_reserved_out = 1'b0;
        case (lowpass_q[`PDC_LOWPASS_HI:`PDC_LOWPASS_LO])
            `PDC_LPF_370_2P: begin
                lowpass_code_out = 2'd0;
                lowpass_poles_out = 3'd2;
            end
            `PDC_LPF_400_3P: begin
                lowpass_code_out = 2'd1;
                lowpass_poles_out = 3'd3;
            end
            `PDC_LPF_800_4P: begin
                lowpass_code_out = 2'd2;
                lowpass_poles_out = 3'd4;
            end
            `PDC_LPF_1000_4P: begin
                lowpass_code_out = 2'd3;
                lowpass_poles_out = 3'd4;
            end
            default: begin
                lowpass_code_out = 2'd0;
                lowpass_poles_out = 3'd2;
                lowpass_reserved_out = 1'b1;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // sensor data slots

    // fixed self-test patterns
    assign st_force = (st_code == `PDC_ST_FORCE_0) | (st_code == `PDC_ST_FORCE_1)
                    | (st_code == `PDC_ST_FORCE_2) | (st_code == `PDC_ST_FORCE_3);
    always @* begin
        case (st_code)
            `PDC_ST_FORCE_1: st_pattern = `PDC_PAT_1;
            `PDC_ST_FORCE_2: st_pattern = `PDC_PAT_2;
            `PDC_ST_FORCE_3: st_pattern = `PDC_PAT_3;
            default: st_pattern = `PDC_PAT_0;
        endcase
    end

    assign slot0_next = slot_pick(slot0_type, rel_pressure_in, abs_pressure_in,
                                  ref_pressure_in, temperature_in);
    assign slot1_next = slot_pick(slot1_type, rel_pressure_in, abs_pressure_in,
                                  ref_pressure_in, temperature_in);

    // path hold: set by a path reset, released by dsp init done
    always @(posedge clk_in) begin
        if (reset_in) begin
            path_hold_q <= 1'b0;
            data_ready_out <= 1'b0;
        end else begin
            if (dsp_path_reset_out) begin
                path_hold_q <= 1'b1;
            end else if (dsp_init_done_in) begin
                path_hold_q <= 1'b0;
            end
            data_ready_out <= ~path_hold_q & ~dsp_path_reset_out & dsp_init_done_in;
        end
    end

    // slot 0 follows both raw and interpolated ticks; slot 1 only raw ones
    always @(posedge clk_in) begin
        if (reset_in) begin
            slot0_data_out <= `PDC_RST_DATA;
            slot1_data_out <= `PDC_RST_DATA;
        end else if (st_force) begin
            slot0_data_out <= st_pattern;
            slot1_data_out <= st_pattern;
        end else if (dsp_path_reset_out || path_hold_q) begin
            slot0_data_out <= `PDC_RST_DATA;
            slot1_data_out <= `PDC_RST_DATA;
        end else begin
            if (sample_tick_in || interp_tick_in) begin
                slot0_data_out <= slot0_next;
            end
            if (sample_tick_in) begin
                slot1_data_out <= slot1_next;
            end
        end
    end

    // link words follow the slot registers with psi5 substitution
    always @(posedge clk_in) begin
        if (reset_in) begin
            slot0_link_out <= `PDC_RST_DATA;
            slot1_link_out <= `PDC_RST_DATA;
        end else begin
            slot0_link_out <= link_word(slot0_type, slot0_data_out, psi5_mode_in);
            slot1_link_out <= link_word(slot1_type, slot1_data_out, psi5_mode_in);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // interrupt pin

    // open drain: drive only while asserted; pull current sets the idle level
    assign int_pin_oe_out = int_pin_enable_in & int_request_in;
    assign int_pin_out = ~filter_pin_q[`PDC_INT_MODE_BIT];
    assign int_pullup_en_out = int_pin_enable_in & filter_pin_q[`PDC_INT_MODE_BIT];
    assign int_pulldown_en_out = int_pin_enable_in & ~filter_pin_q[`PDC_INT_MODE_BIT];

endmodule // pdc_config_bank
`default_nettype wire

// ==== verif/pdc_checker.sv ====
/*
 * checker for the configuration bank: access, path reset, restart, pin mode.
 * assumes it is bound to pdc_config_bank and sees only that module's ports.
 */
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
module pdc_checker (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic reg_rd_valid_out,
    input wire logic reg_refused_out,
    input wire logic dsi3_mode_in,
    input wire logic psi5_diag_mode_in,
    input wire logic dsp_path_reset_out,
    input wire logic ref_filter_restart_out,
    input wire logic ref_rate_limit_bypass_out,
    input wire logic [1:0] lowpass_code_out,
    input wire logic [2:0] lowpass_poles_out,
    input wire logic lowpass_reserved_out,
    input wire logic int_pin_enable_in,
    input wire logic int_request_in,
    input wire logic int_pin_out,
    input wire logic int_pin_oe_out,
    input wire logic int_pullup_en_out,
    input wire logic int_pulldown_en_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // access is open only in the two command modes
    wire logic ok_mode = dsi3_mode_in | psi5_diag_mode_in;

    // register access
    rd_answer_a: assert property (reg_rd_in && ok_mode |=> reg_rd_valid_out)
        else $error("read not answered");
    access_refuse_a: assert property ((reg_rd_in || reg_wr_in) && !ok_mode |=>
        reg_refused_out && !reg_rd_valid_out && !dsp_path_reset_out)
        else $error("access outside command modes not refused");
    path_reset_a: assert property (dsp_path_reset_out |->
        $past(reg_wr_in && ok_mode && reg_addr_in == 8'h42))
        else $error("path reset without output type write");
    ref_restart_a: assert property (ref_filter_restart_out |->
        $past(reg_wr_in && reg_addr_in == 8'h43 && reg_wdata_in[7]))
        else $error("restart without set bit write");
    bypass_bit_a: assert property (reg_wr_in && ok_mode && reg_addr_in == 8'h43 |=>
        ref_rate_limit_bypass_out == $past(reg_wdata_in[4]))
        else $error("bypass does not follow written bit");
    // filter decode stays on the reset choice here
    lowpass_fixed_a: assert property (lowpass_code_out == 2'b00 &&
        lowpass_poles_out == 3'd2 && !lowpass_reserved_out)
        else $error("lowpass decode not 370 Hz two pole");
    // interrupt pin
    int_hiz_a: assert property (!int_pin_enable_in |-> !int_pin_oe_out &&
        !int_pullup_en_out && !int_pulldown_en_out)
        else $error("disabled pin not high impedance");
    int_mode_a: assert property (int_pin_enable_in |-> int_pullup_en_out !=
        int_pulldown_en_out && int_pin_out == int_pulldown_en_out &&
        int_pin_oe_out == int_request_in)
        else $error("pin mode wrong");
endmodule // pdc_checker

bind pdc_config_bank pdc_checker i_chk (.*);
`default_nettype wire

// ==== verif/tb.sv ====
/*
 * testbench for the configuration bank: register rows, then restart,
 * self test, path reset, slot types, link substitution and interrupt pin.
 * assumes pdc_config_bank with the checker bound to it.
 */
`default_nettype none
`include "pdc_consts.vh"

//////////////////////////////////////////////////////////////////////////////
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, reset_in = 1, reg_wr_in = 0, reg_rd_in = 0, dsi3_mode_in = 1;
    logic psi5_diag_mode_in = 0, psi5_mode_in = 0, dsp_init_done_in = 1;
    logic sample_tick_in = 0, interp_tick_in = 0, int_pin_enable_in = 0, int_request_in = 0;
    logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, rdv;
    logic [15:0] rel_pressure_in = 16'h1111, abs_pressure_in = 16'h2222;
    logic [15:0] ref_pressure_in = 16'h3333, temperature_in = 16'h4444;
    wire logic [7:0] reg_rdata_out, cfg_check_out;
    wire logic reg_rd_valid_out, reg_refused_out, dsp_path_reset_out, data_ready_out;
    wire logic [15:0] slot0_data_out, slot1_data_out, slot0_link_out, slot1_link_out;
    wire logic [1:0] lowpass_code_out;
    wire logic [2:0] lowpass_poles_out;
    wire logic lowpass_reserved_out, ref_filter_restart_out, ref_rate_limit_bypass_out;
    wire logic [3:0] self_test_select_out;
    wire logic int_pin_out, int_pin_oe_out, int_pullup_en_out, int_pulldown_en_out;
    int n_errors = 0, n_checks = 0, cyc = 0, n_restart = 0;
    // rows: offset, write value, read back value; unmapped offsets read zero
    logic [23:0] rows [5] = '{24'h42_a5a5, 24'h43_ffff, 24'h44_f0f0, 24'h45_7700, 24'h41_3300};
    logic [15:0] pats [4] = '{16'h0000, 16'h0aaa, 16'h5555, 16'hffff};

    pdc_config_bank i_dut (.*);

    // clock, timeout and restart pulse count
    initial forever #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (ref_filter_restart_out === 1'b1) n_restart++;
        if (cyc == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    function automatic logic [15:0] pv(input int t);
        return t == 0 ? rel_pressure_in : t == 1 ? abs_pressure_in :
            t == 2 ? ref_pressure_in : temperature_in;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1 reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1;
        @(posedge clk_in);
        #1 reg_wr_in = 0;
    endtask
    // the answer stands one cycle, so it is taken right after the answering edge
    task automatic rd(input logic [7:0] a);
        @(posedge clk_in);
        #1 reg_addr_in = a;
        reg_rd_in = 1;
        @(posedge clk_in);
        #1 reg_rd_in = 0;
        rdv = reg_rdata_out;
    endtask
    task automatic tick(input bit interp, input int w);
        repeat (w) @(posedge clk_in);
        #1 sample_tick_in = !interp;
        interp_tick_in = interp;
        @(posedge clk_in);
        #1 sample_tick_in = 0;
        interp_tick_in = 0;
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_in);
        #1 reset_in = 0;
        for (int i = 0; i < 3; i++) begin
            rd(8'h42 + 8'(i));
            chk("reset value", {8'h00, rdv}, 16'h0000);
            chk("read valid", {15'h0, reg_rd_valid_out}, 16'h0001);
        end
        foreach (rows[i]) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]);
            chk("read back", {8'h00, rdv}, {8'h00, rows[i][7:0]});
        end
        chk("check word", {8'h00, cfg_check_out}, 16'h005a);
        chk("bypass", {15'h0, ref_rate_limit_bypass_out}, 16'h0001);
        // restart counts only clear-to-set writes
        wr(8'h43, 8'h00);
        n_restart = 0;
        wr(8'h43, 8'h80);
        wr(8'h43, 8'h80);
        wr(8'h43, 8'h00);
        wr(8'h43, 8'h80);
        repeat (2) @(posedge clk_in);
        #1 chk("restarts", 16'(n_restart), 16'h0002);
        // refused access leaves the register alone
        dsi3_mode_in = 0;
        wr(8'h44, 8'h55);
        rd(8'h44);
        chk("refused", {14'h0, reg_refused_out, reg_rd_valid_out}, 16'h0002);
        chk("refused data", {8'h00, rdv}, 16'h0000);
        psi5_diag_mode_in = 1;
        rd(8'h44);
        chk("after refusal", {8'h00, rdv}, 16'h00f0);
        for (int k = 4; k < 8; k++) begin
            wr(8'h44, {4'(k), 4'h0});
            repeat (2) @(posedge clk_in);
            #1 chk("test select", {12'h0, self_test_select_out}, 16'(k));
            chk("test slot0", slot0_data_out, pats[k - 4]);
            chk("test slot1", slot1_data_out, pats[k - 4]);
        end
        wr(8'h44, 8'h00);
        // a changed output type holds the path until initialised
        dsp_init_done_in = 0;
        wr(8'h42, 8'h04);
        chk("path reset", {15'h0, dsp_path_reset_out}, 16'h0001);
        repeat (3) @(posedge clk_in);
        #1 chk("ready held", {15'h0, data_ready_out}, 16'h0000);
        // data ready returns once the path reports itself initialised
        dsp_init_done_in = 1;
        repeat (3) @(posedge clk_in);
        #1 chk("ready again", {15'h0, data_ready_out}, 16'h0001);
        psi5_mode_in = 1;
        for (int t = 0; t < 4; t++) begin
            wr(8'h42, {1'b0, 2'(t), 1'b0, 2'(3 - t), 2'b00});
            tick(0, 3);
            chk("slot0", slot0_data_out, pv(t));
            chk("slot1", slot1_data_out, pv(3 - t));
            chk("link0", slot0_link_out, (t == 1 || t == 2) ? 16'h01f4 : pv(t));
            chk("link1", slot1_link_out, (t == 1 || t == 2) ? 16'h01f4 : pv(3 - t));
        end
        psi5_mode_in = 0;
        wr(8'h42, 8'h20);
        tick(0, 3);
        chk("dsi3 link", slot0_link_out, 16'h2222);
        rel_pressure_in = 16'h7777;
        abs_pressure_in = 16'h8888;
        tick(1, 0);
        chk("interp slot0", slot0_data_out, 16'h8888);
        chk("interp slot1", slot1_data_out, 16'h1111);
        // pin: enable, request, pulldown then pullup mode, then disabled
        int_pin_enable_in = 1;
        int_request_in = 1;
        wr(8'h43, 8'h00);
        #1 chk("pin high", {12'h0, int_pin_oe_out, int_pin_out, int_pullup_en_out,
            int_pulldown_en_out}, 16'h000d);
        wr(8'h43, 8'h04);
        #1 chk("pin low", {12'h0, int_pin_oe_out, int_pin_out, int_pullup_en_out,
            int_pulldown_en_out}, 16'h000a);
        int_pin_enable_in = 0;
        #1 chk("pin off", {13'h0, int_pin_oe_out, int_pullup_en_out,
            int_pulldown_en_out}, 16'h0000);
        // mid-run reset clears registers, slots and the ready level again
        reset_in = 1;
        repeat (2) @(posedge clk_in);
        #1 reset_in = 0;
        chk("reset slots", slot0_data_out | slot1_data_out, 16'h0000);
        chk("reset ready", {15'h0, data_ready_out}, 16'h0000);
        chk("reset check word", {8'h00, cfg_check_out}, 16'h0000);
        rd(8'h42);
        chk("reset reread", {8'h00, rdv}, 16'h0000);
        complete_run();
    end
endmodule // tb
`default_nettype wire
